// ===== common/lcd_column_defs.vh
// Purpose: Shared constants for the LCD segment column driver.
// Assumes: Included by its bare name from the design and bench files.
// Notes: Drive levels are 2-bit codes; the analog switches sit outside this logic.
`ifndef LCD_COLUMN_DEFS_VH
`define LCD_COLUMN_DEFS_VH

// Width of the pixel bus and number of segment outputs.
`define PIXEL_BUS_W 8
`define SEG_COUNT 240
// Number of byte slots in the enable register (240 / 8).
`define SLOT_COUNT 30
// Width of the level code that drives each segment output.
`define LEVEL_W 2

// Level codes for the four drive rails.
`define LEVEL_TOP 2'h0
`define LEVEL_UPPER_MID 2'h1
`define LEVEL_LOWER_MID 2'h2
`define LEVEL_BOTTOM 2'h3

// Bit positions inside the vector of synchronised pin inputs.
`define SYNC_W 15
`define SYNC_SCK 0
`define SYNC_LP 1
`define SYNC_FR 2
`define SYNC_BLANK 3
`define SYNC_SHL 4
`define SYNC_PORT_A 5
`define SYNC_PORT_B 6
`define SYNC_BUS_LO 7

// Reset value of the pin synchronisers and of the filtered pin levels.
`define SYNC_RESET 15'h0000

`endif

// ===== hw/lcd_segment_column_driver.v
// Purpose: Column driver logic for a dot-matrix LCD: collects 240 pixel bits, latches them, picks drive levels.
// Assumes: All pins are asynchronous to clk and are oversampled; the shift clock runs well below clk / 4.
// Notes: Chain pins are active low; each segment output is a 2-bit level code for the analog rail switches.
//
// What this block does
// - The enable register is a bidirectional one-hot shift register whose direction follows shift_dir_sel and whose stages steer each bus byte into the data register.
// - While the chip is not enabled, the internal shift clock and internal data bus are held low to save power.
// - The chip notices by itself that 240 bits have been taken and then activates its enable output for the next driver.
// - Where a byte lands depends only on the enable register position, never on the number of extra shift clocks.
// - Each falling edge of line_latch_pulse copies the whole data register into the output latch.
// - With display_blank_n high, bit and frame_polarity pick top, bottom, upper mid or lower mid as 11, 10, 01, 00.
// - With display_blank_n low, every segment output goes to the bottom level.
// - One 8-bit byte is taken per shift clock while the chip is enabled.
// - A line latch pulse returns the enable output to its inactive level, ready for the next line.
// - shift_dir_sel sets both the byte ordering and which chain pin is the input and which the output.
`timescale 1ns/10ps
`include "lcd_column_defs.vh"

module lcd_segment_column_driver (
  input wire clk,
  input wire rst_b,
  input wire clk_en,
  input wire pixel_shift_clock,
  input wire line_latch_pulse,
  input wire [`PIXEL_BUS_W-1:0] pixel_bus,
  input wire frame_polarity,
  input wire display_blank_n,
  input wire shift_dir_sel,
  input wire chain_port_a_in,
  output wire chain_port_a_out,
  output wire chain_port_a_oe,
  input wire chain_port_b_in,
  output wire chain_port_b_out,
  output wire chain_port_b_oe,
  output wire [`SEG_COUNT*`LEVEL_W-1:0] seg_outputs
);

  // Pick the rail for one segment from its latched bit, the frame polarity and the blank input.
  function [`LEVEL_W-1:0] pick_level;
    input data_bit;
    input polarity;
    input blank_n;
    begin
      if (!blank_n) begin
        pick_level = `LEVEL_BOTTOM;
      end else if (data_bit) begin
        pick_level = polarity ? `LEVEL_TOP : `LEVEL_BOTTOM;
      end else begin
        pick_level = polarity ? `LEVEL_UPPER_MID : `LEVEL_LOWER_MID;
      end
    end
  endfunction

  // Reverse the bit order of one bus byte, used for the opposite shift direction.
  function [`PIXEL_BUS_W-1:0] reverse_byte;
    input [`PIXEL_BUS_W-1:0] value;
    integer i;
    begin
      reverse_byte = {`PIXEL_BUS_W{1'b0}};
      for (i = 0; i < `PIXEL_BUS_W; i = i + 1) begin
        reverse_byte[i] = value[`PIXEL_BUS_W-1-i];
      end
    end
  endfunction

  wire [`SYNC_W-1:0] pins_raw;
  reg [`SYNC_W-1:0] sync1_reg;
  reg [`SYNC_W-1:0] sync2_reg;
  reg [`SYNC_W-1:0] sync3_reg;
  reg [`SYNC_W-1:0] pin_level_reg;
  reg [1:0] rst_sync_reg;
  wire rst_int_b;

  reg [`SLOT_COUNT-1:0] enable_reg;
  reg [`SLOT_COUNT-1:0] enable_next;
  reg busy_reg;
  reg done_reg;
  reg chain_out_n_reg;
  reg port_a_out_reg;
  reg port_a_oe_reg;
  reg port_b_out_reg;
  reg port_b_oe_reg;
  reg [`SEG_COUNT-1:0] data_reg;
  reg [`SEG_COUNT-1:0] latch_reg;
  reg [`SEG_COUNT*`LEVEL_W-1:0] seg_reg;

  wire shl;
  wire chain_in_n;
  wire chip_enabled;
  wire sck_level;
  wire sck_int;
  wire sck_fall;
  wire lp_fall;
  wire [`PIXEL_BUS_W-1:0] bus_int;
  wire [`PIXEL_BUS_W-1:0] bus_ordered;
  wire [`SLOT_COUNT-1:0] first_slot;
  wire [`SLOT_COUNT-1:0] last_slot;

  // Reset image of the pin synchronisers, indexed bit by bit so each flip-flop gets exactly one bit.
  localparam [`SYNC_W-1:0] sync_reset_value = `SYNC_RESET;

  // The reset is asserted at once and released through two flip-flops on clk.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_int_b = rst_sync_reg[1];

  assign pins_raw = {pixel_bus, chain_port_b_in, chain_port_a_in, shift_dir_sel, display_blank_n,
                     frame_polarity, line_latch_pulse, pixel_shift_clock};

  // Every pin passes three flip-flops; a new level is accepted only once stages two and three agree,
  // which rejects a single-sample glitch at the cost of one extra cycle of latency.
  genvar g;
  generate
    for (g = 0; g < `SYNC_W; g = g + 1) begin : pin_sync
      always @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
          sync1_reg[g] <= sync_reset_value[g];
          sync2_reg[g] <= sync_reset_value[g];
          sync3_reg[g] <= sync_reset_value[g];
          pin_level_reg[g] <= sync_reset_value[g];
        end else if (clk_en) begin
          sync1_reg[g] <= pins_raw[g];
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
          if (sync2_reg[g] == sync3_reg[g]) begin
            pin_level_reg[g] <= sync3_reg[g];
          end
        end
      end
    end
  endgenerate

  // The direction pin decides which chain pin listens: low listens on port b, high on port a.
  assign shl = pin_level_reg[`SYNC_SHL];
  assign chain_in_n = shl ? pin_level_reg[`SYNC_PORT_A] : pin_level_reg[`SYNC_PORT_B];

  // The chip takes data only while its upstream enable is low and its own quota is not yet full.
  assign chip_enabled = !chain_in_n && !done_reg;

  // Internal clock and bus are gated low while disabled so the capture logic sits still.
  assign sck_level = pin_level_reg[`SYNC_SCK];
  assign sck_int = chip_enabled & sck_level;
  assign bus_int = chip_enabled ? pin_level_reg[`SYNC_BUS_LO +: `PIXEL_BUS_W] : {`PIXEL_BUS_W{1'b0}};

  // Falling edges are taken from the filtered level and the new filtered value.
  // The shift edge comes from the gated internal clock, so a disabled chip never sees one.
  assign sck_fall = sck_int && (sync2_reg[`SYNC_SCK] == sync3_reg[`SYNC_SCK])
                    && !sync3_reg[`SYNC_SCK];
  assign lp_fall = pin_level_reg[`SYNC_LP] && (sync2_reg[`SYNC_LP] == sync3_reg[`SYNC_LP])
                   && !sync3_reg[`SYNC_LP];

  // The byte is mirrored in the opposite direction so the first bit lands at the far end.
  assign bus_ordered = shl ? bus_int : reverse_byte(bus_int);

  assign first_slot = shl ? {{(`SLOT_COUNT-1){1'b0}}, 1'b1} : {1'b1, {(`SLOT_COUNT-1){1'b0}}};
  assign last_slot = shl ? {1'b1, {(`SLOT_COUNT-1){1'b0}}} : {{(`SLOT_COUNT-1){1'b0}}, 1'b1};

  // Next state of the one-hot enable register: parked at the first slot until a line starts,
  // then stepped once per accepted byte in the chosen direction.
  always @* begin
    enable_next = enable_reg;
    if (lp_fall || !busy_reg) begin
      enable_next = first_slot;
      if (sck_fall) begin
        enable_next = shl ? {first_slot[`SLOT_COUNT-2:0], 1'b0} : {1'b0, first_slot[`SLOT_COUNT-1:1]};
      end
    end else if (sck_fall) begin
      enable_next = shl ? {enable_reg[`SLOT_COUNT-2:0], 1'b0} : {1'b0, enable_reg[`SLOT_COUNT-1:1]};
    end
  end

  // Enable register, quota detection and the chain output.
  always @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      enable_reg <= {{(`SLOT_COUNT-1){1'b0}}, 1'b1};
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      chain_out_n_reg <= 1'b1;
    end else if (clk_en) begin
      enable_reg <= enable_next;
      if (lp_fall) begin
        busy_reg <= sck_fall; // A shift edge in the latch cycle already opens the new line.
        done_reg <= 1'b0;
        chain_out_n_reg <= 1'b1;
      end else if (sck_fall) begin
        busy_reg <= 1'b1;
        if ((busy_reg ? enable_reg : first_slot) == last_slot) begin
          done_reg <= 1'b1;
          chain_out_n_reg <= 1'b0;
        end
      end
    end
  end

  // Chain pin drivers: the pin that is not the input drives the enable onward.
  always @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      port_a_out_reg <= 1'b1;
      port_a_oe_reg <= 1'b0;
      port_b_out_reg <= 1'b1;
      port_b_oe_reg <= 1'b0;
    end else if (clk_en) begin
      port_a_oe_reg <= !shl;
      port_b_oe_reg <= shl;
      port_a_out_reg <= chain_out_n_reg;
      port_b_out_reg <= chain_out_n_reg;
    end
  end

  // Each slot stores the whole byte when its enable stage is set, so extra clocks never move data.
  generate
    for (g = 0; g < `SLOT_COUNT; g = g + 1) begin : data_slot
      always @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
          data_reg[g*`PIXEL_BUS_W +: `PIXEL_BUS_W] <= {`PIXEL_BUS_W{1'b0}};
        end else if (clk_en && sck_fall && ((busy_reg && !lp_fall) ? enable_reg[g] : first_slot[g])) begin
          data_reg[g*`PIXEL_BUS_W +: `PIXEL_BUS_W] <= bus_ordered;
        end
      end
    end
  endgenerate

  // Output latch: loaded only on the latch pulse falling edge and held otherwise.
  always @(posedge clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      latch_reg <= {`SEG_COUNT{1'b0}};
    end else if (clk_en && lp_fall) begin
      latch_reg <= data_reg;
    end
  end

  // Level selection is registered so every segment output comes straight from a flip-flop;
  // reset shows the bottom level, the safe rail while the drive supply settles.
  generate
    for (g = 0; g < `SEG_COUNT; g = g + 1) begin : seg_level
      always @(posedge clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
          seg_reg[g*`LEVEL_W +: `LEVEL_W] <= `LEVEL_BOTTOM;
        end else if (clk_en) begin
          seg_reg[g*`LEVEL_W +: `LEVEL_W] <= pick_level(latch_reg[g], pin_level_reg[`SYNC_FR],
                                                         pin_level_reg[`SYNC_BLANK]);
        end
      end
    end
  endgenerate

  // Every output pin comes straight from its register.
  assign chain_port_a_out = port_a_out_reg;
  assign chain_port_a_oe = port_a_oe_reg;
  assign chain_port_b_out = port_b_out_reg;
  assign chain_port_b_oe = port_b_oe_reg;
  assign seg_outputs = seg_reg;

endmodule // lcd_segment_column_driver

// ===== tb/lcd_column_checker_assertions.sv
// Purpose: Port assertions for the LCD column driver.
// Assumes: Pin paths settle within eight clk cycles.
// Notes: Level and direction checks wait 31 cycles out of reset, past the internal release; chain checks do not wait.
`timescale 1ns/10ps
`include "lcd_column_defs.vh"
module lcd_column_checker (
  input wire clk,
  input wire rst_b,
  input wire clk_en,
  input wire pixel_shift_clock,
  input wire line_latch_pulse,
  input wire frame_polarity,
  input wire display_blank_n,
  input wire shift_dir_sel,
  input wire chain_port_a_in,
  input wire chain_port_b_in,
  input wire chain_port_a_out,
  input wire chain_port_b_out,
  input wire chain_port_a_oe,
  input wire chain_port_b_oe,
  input wire [`SEG_COUNT*`LEVEL_W-1:0] seg_outputs
);
  reg [4:0] w_reg, age_reg;
  reg [3:0] lp_reg;
  reg [5:0] cnt_reg;
  reg [`SEG_COUNT-1:0] hi;
  integer i;
  // Level checks wait out reset and skip cycles in which the clock enable freezes the block.
  wire ok = (w_reg == 5'h1f) && clk_en;
  wire en_n = shift_dir_sel ? chain_port_a_in : chain_port_b_in;
  // While not blanked, the upper bit of each level code follows the frame phase alone.
  always @* for (i = 0; i < `SEG_COUNT; i = i + 1) hi[i] = seg_outputs[2*i+1];
  // Ages since reset, latch fall and level pin change; enabled bytes since the latch fall.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_reg <= 5'h00;
      age_reg <= 5'h00;
      lp_reg <= 4'h0;
      cnt_reg <= 6'h00;
    end else begin
      w_reg <= w_reg + {4'h0, w_reg != 5'h1f};
      lp_reg <= $fell(line_latch_pulse) ? 4'h0 : lp_reg + {3'h0, lp_reg != 4'hf};
      age_reg <= ($fell(line_latch_pulse) || $changed({frame_polarity, display_blank_n}) || !clk_en) ? 5'h00 :
        age_reg + {4'h0, age_reg != 5'h1f};
      if ($fell(line_latch_pulse))
        cnt_reg <= 6'h00;
      else if ($fell(pixel_shift_clock) && !en_n && cnt_reg != 6'h3f)
        cnt_reg <= cnt_reg + 6'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_OE_DIR:
    assert property ((ok && $stable(shift_dir_sel)) [*8] |->
      (chain_port_a_oe != shift_dir_sel && chain_port_b_oe == shift_dir_sel)) else $error("bad chain direction");
  AST_BLANK:
    assert property ((ok && !display_blank_n) [*8] |-> seg_outputs == {`SEG_COUNT{`LEVEL_BOTTOM}})
      else $error("blank level wrong");
  AST_FR_PHASE:
    assert property ((ok && display_blank_n && $stable(frame_polarity)) [*8] |-> hi == {`SEG_COUNT{!frame_polarity}})
      else $error("frame phase wrong");
  AST_SEG_HOLD:
    assert property ((ok && age_reg > 5'h0a) |-> $stable(seg_outputs)) else $error("segments moved");
  AST_REARM:
    assert property ($fell(line_latch_pulse) |-> ##[3:8] (chain_port_a_out && chain_port_b_out))
      else $error("chain not rearmed");
  AST_PASS_ON:
    assert property (($fell(pixel_shift_clock) && !en_n && cnt_reg == 6'h1d) |->
      ##[3:8] (!chain_port_a_out && !chain_port_b_out)) else $error("chain not passed on");
  AST_NO_EARLY:
    assert property ($fell(chain_port_a_out) |-> cnt_reg >= 6'h1e) else $error("chain passed early");
  AST_OUT_STANDS:
    assert property ($rose(chain_port_a_out) |-> lp_reg < 4'h9) else $error("chain released early");
endmodule // lcd_column_checker
bind lcd_segment_column_driver lcd_column_checker chk (.clk, .rst_b, .clk_en, .pixel_shift_clock, .line_latch_pulse,
  .frame_polarity, .display_blank_n, .shift_dir_sel, .chain_port_a_in, .chain_port_b_in, .chain_port_a_out,
  .chain_port_b_out, .chain_port_a_oe, .chain_port_b_oe, .seg_outputs);

// ===== tb/lcd_controller_model.sv
// Purpose: Display controller model feeding one column driver.
// Assumes: Steps on the falling edge of clk.
// Notes: The shift clock idles low; a released bus shows the inverse byte.
`timescale 1ns/10ps
`include "lcd_column_defs.vh"
module lcd_controller_model (
  input wire clk,
  output reg pixel_shift_clock = 1'b0,
  output reg [`PIXEL_BUS_W-1:0] pixel_bus = 8'h00,
  output reg line_latch_pulse = 1'b0
);
  integer k;
  // Bytes first to n-1, one per shift clock; extra bytes wrap to the line start.
  // The shift clock is high and low for four cycles each (100 ns) and stands low for gap more cycles.
  task send_bytes(input [`SEG_COUNT-1:0] d, input integer first, input integer n, input integer gap);
    for (k = first; k < n; k = k + 1) begin
      @(negedge clk);
      pixel_bus = d[8*(k%`SLOT_COUNT)+:8];
      pixel_shift_clock = 1'b1;
      repeat (4) @(negedge clk);
      pixel_shift_clock = 1'b0;
      repeat (3) @(negedge clk);
      pixel_bus = ~pixel_bus;
      repeat (gap) @(negedge clk);
    end
  endtask
  // The falling edge of the pulse moves the line to the outputs.
  task latch_line;
    begin
      @(negedge clk);
      line_latch_pulse = 1'b1;
      repeat (4) @(negedge clk);
      line_latch_pulse = 1'b0;
    end
  endtask
endmodule // lcd_controller_model

// ===== tb/lcd_segment_column_driver_tb.sv
// Purpose: Self-checking bench for the LCD column driver.
// Assumes: The driver is first in its cascade.
// Notes: Lines are random from a fixed seed; exp_seg works out the levels.
`timescale 1ns/10ps
`include "lcd_column_defs.vh"
module lcd_segment_column_driver_tb;
  localparam W = `SEG_COUNT * `LEVEL_W;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg fr = 1'b1;
  reg blank_n = 1'b1;
  reg dir = 1'b1;
  reg chain_in = 1'b0;
  reg ce = 1'b1;
  reg [`SEG_COUNT-1:0] line = {`SEG_COUNT{1'b0}};
  integer fails = 0;
  integer n_tests = 0;
  integer t, j;
  wire sck, lp, a_in, a_out, a_oe, b_in, b_out, b_oe;
  wire [`PIXEL_BUS_W-1:0] bus;
  wire [W-1:0] seg;
  // Only the selected chain pin is fed from outside; the other reads back its own output, or is pulled up while not driven.
  assign a_in = a_oe ? a_out : (dir ? chain_in : 1'b1);
  assign b_in = b_oe ? b_out : (dir ? 1'b1 : chain_in);
  always #12.5 clk = ~clk;
  lcd_segment_column_driver dut (.clk(clk), .rst_b(rst_b), .clk_en(ce), .pixel_shift_clock(sck),
    .line_latch_pulse(lp), .pixel_bus(bus), .frame_polarity(fr), .display_blank_n(blank_n), .shift_dir_sel(dir),
    .chain_port_a_in(a_in), .chain_port_a_out(a_out), .chain_port_a_oe(a_oe), .chain_port_b_in(b_in),
    .chain_port_b_out(b_out), .chain_port_b_oe(b_oe), .seg_outputs(seg));
  lcd_controller_model ctl (.clk(clk), .pixel_shift_clock(sck), .pixel_bus(bus), .line_latch_pulse(lp));
  // Levels for a line under a given direction, frame phase and blanking.
  function [W-1:0] exp_seg(input [`SEG_COUNT-1:0] d, input sh, input f, input bl);
    integer g;
    reg b;
    begin
      for (g = 0; g < `SEG_COUNT; g = g + 1) begin
        b = sh ? d[g] : d[8 * (`SLOT_COUNT - 1 - g / 8) + 7 - g % 8];
        exp_seg[2*g+:2] = !bl ? `LEVEL_BOTTOM : b ? (f ? `LEVEL_TOP : `LEVEL_BOTTOM) :
          (f ? `LEVEL_UPPER_MID : `LEVEL_LOWER_MID);
      end
    end
  endfunction
  task chk(input [W-1:0] got, input [W-1:0] want);
    begin
      n_tests = n_tests + 1;
      if (got !== want) begin
        fails = fails + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, want);
      end
    end
  endtask
  task chk_pin(input got, input want);
    chk({479'h0, got}, {479'h0, want});
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // 29 bytes, a pause at the quota edge, the rest, then the latch pulse.
  task run_line(input integer n);
    begin
      for (j = 0; j < 8; j = j + 1) line = {line[`SEG_COUNT-33:0], $urandom};
      if (t == 4) line = {`SEG_COUNT{1'b1}};
      ctl.send_bytes(line, 0, 29, $urandom % 8);
      repeat (8) @(negedge clk);
      chk_pin(a_out, 1'b1);
      ctl.send_bytes(line, 29, n, 0);
      repeat (8) @(negedge clk);
      chk_pin(b_out, 1'b0);
      chk_pin(a_oe, !dir);
      ctl.latch_line;
      repeat (10) @(negedge clk);
      chk(seg, exp_seg(line, dir, fr, 1'b1));
      chk_pin(a_out, 1'b1);
    end
  endtask
  initial begin
    j = $urandom(32'hf851381d);
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (20) @(negedge clk);
    for (t = 0; t < 6; t = t + 1) begin
      dir = t[0];
      fr = t[1];
      repeat (12) @(negedge clk);
      run_line(t == 3 ? 32 : 30);
      $display("test %0d done", t);
    end
    // A frame change while the clock enable is low must not reach the outputs until it is high again.
    ce = 1'b0;
    fr = !fr;
    repeat (10) @(negedge clk);
    chk(seg, exp_seg(line, dir, !fr, 1'b1));
    ce = 1'b1;
    repeat (10) @(negedge clk);
    chk(seg, exp_seg(line, dir, fr, 1'b1));
    blank_n = 1'b0;
    repeat (10) @(negedge clk);
    chk(seg, {`SEG_COUNT{`LEVEL_BOTTOM}});
    $display("level test done");
    blank_n = 1'b1;
    chain_in = 1'b1;
    repeat (12) @(negedge clk);
    ctl.send_bytes(~line, 0, 30, 0);
    repeat (8) @(negedge clk);
    chk_pin(a_out, 1'b1);
    ctl.latch_line;
    repeat (10) @(negedge clk);
    chk(seg, exp_seg(line, dir, fr, 1'b1));
    $display("disabled test done");
    end_of_test;
  end
  // A hang costs a mismatch and ends the run.
  initial begin
    #2000000;
    fails = fails + 1;
    end_of_test;
  end
endmodule // lcd_segment_column_driver_tb
